// ### tb/cfg_sleep_ctrl_asserts.sv
// Checker: port assertions for configuration decode and sleep sequencing
`timescale 1ns/1ps
module cfg_sleep_ctrl_asserts (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] addr,
  input wire logic [13:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [13:0] rdata,
  input wire logic        por_event,
  input wire logic        wdt_timeout,
  input wire logic [12:0] pc_now,
  input wire logic [3:0]  irq_flags,
  input wire logic        prog_mem_protect,
  input wire logic        debugger_pins,
  input wire logic        data_eeprom_locked,
  input wire logic        brown_out_reset,
  input wire logic        powerup_timer,
  input wire logic        watchdog_run,
  input wire logic [1:0]  osc_mode,
  input wire logic        osc_drive_on,
  input wire logic        wdt_clear,
  input wire logic        core_hold,
  input wire logic        take_vector,
  input wire logic [12:0] prefetch_addr,
  input wire logic [12:0] vector_addr,
  input wire logic        powerdown_flag,
  input wire logic        timeout_flag,
  input wire logic [7:0]  port_out,
  input wire logic [7:0]  port_oe
);
  // -------------------------------------------------------------
  // Sequences
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A read of the word with no write just before, so decode has settled
  sequence cfg_rd;
    rd_stb && !$past(wr_stb) && addr == cfg_sleep_pkg::CFG_WORD_OFFSET;
  endsequence
  sequence sleep_go;
    wr_stb && wdata[0] && addr == cfg_sleep_pkg::SLEEP_CTRL_OFFSET && irq_flags == 4'h0
      && !core_hold && !$past(core_hold) && !por_event && !wdt_timeout;
  endsequence
  sequence osc_back;
    core_hold && $rose(osc_drive_on);
  endsequence
  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  chk_unimpl_bit: assert property (cfg_rd |=> rdata[10])
    else $error("unimplemented bit read low");
  chk_protect_decode: assert property (cfg_rd |=>
    prog_mem_protect == (rdata[13:12] == 2'h0 && rdata[5:4] == 2'h0))
    else $error("program protect decode wrong");
  chk_debug_osc: assert property (cfg_rd |=>
    debugger_pins == !rdata[11] && osc_mode == rdata[1:0])
    else $error("debug pins or oscillator decode wrong");
  chk_bor_timer: assert property (cfg_rd |=>
    brown_out_reset == rdata[6] && powerup_timer == (rdata[6] || !rdata[3]))
    else $error("brown-out or power-up timer decode wrong");
  chk_wdt_eeprom: assert property (cfg_rd |=>
    watchdog_run == rdata[2] && data_eeprom_locked == !rdata[8])
    else $error("watchdog or eeprom lock decode wrong");
  chk_sleep_entry: assert property (sleep_go |=>
    !powerdown_flag && timeout_flag && wdt_clear && !osc_drive_on && core_hold
    && prefetch_addr == $past(pc_now) + 13'h0001)
    else $error("sleep entry effects wrong");
  chk_port_hold: assert property (core_hold && $past(core_hold) |->
    $stable(port_out) && $stable(port_oe))
    else $error("port drive moved while asleep");
  chk_osc_restart: assert property (osc_back |->
    osc_drive_on throughout (core_hold ##[1:8] !core_hold))
    else $error("resume without running oscillator");
  chk_wdt_wake: assert property (core_hold && !osc_drive_on && wdt_timeout
    && irq_flags == 4'h0 |-> ##[1:3] !timeout_flag)
    else $error("watchdog wake left timeout flag set");
  chk_vector_addr: assert property (take_vector |->
    vector_addr == cfg_sleep_pkg::IRQ_VECTOR && ($past(core_hold) || $past(core_hold, 2)))
    else $error("vector taken outside wake-up");
  chk_por_flags: assert property (por_event |=> powerdown_flag && timeout_flag)
    else $error("power-up did not set flags");
endmodule : cfg_sleep_ctrl_asserts

// ### tb/config_word_sleep_wakeup_test.sv
// Testbench: configuration decode and sleep/wake sequencing
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module config_word_sleep_wakeup_test;
  logic        clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, por_event = 1'b0;
  logic        master_clear_n = 1'b1, wdt_timeout = 1'b0, eeprom_write_req = 1'b0;
  logic        prog_mem_protect, debugger_pins, prog_write_ok, data_eeprom_locked;
  logic        prog_mode_pin_func, brown_out_reset, powerup_timer, watchdog_run;
  logic        osc_drive_on, wdt_clear, core_reset, core_hold, take_vector;
  logic        powerdown_flag, timeout_flag;
  logic [1:0]  osc_mode;
  logic [3:0]  irq_flags = 4'h0;
  logic [7:0]  port_out_in = 8'h00, port_oe_in = 8'h00, port_out, port_oe, p;
  logic [12:0] pc_now = 13'h0000, prefetch_addr, vector_addr;
  logic [13:0] rdata, d, w, r;
  logic [15:0] addr = 16'h0000;
  logic [13:0] wdata = 14'h0000;
  int          errors = 0, n_checks = 0, nvec = 0, seed = 13100, pd_m, to_m;
  cfg_sleep_ctrl cfg_sleep_ctrl_inst (.clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .por_event, .master_clear_n, .wdt_timeout, .eeprom_write_req, .pc_now, .irq_flags,
    .port_out_in, .port_oe_in, .prog_mem_protect, .debugger_pins, .prog_write_ok,
    .data_eeprom_locked, .prog_mode_pin_func, .brown_out_reset, .powerup_timer,
    .watchdog_run, .osc_mode, .osc_drive_on, .wdt_clear, .core_reset, .core_hold,
    .take_vector, .prefetch_addr, .vector_addr, .powerdown_flag, .timeout_flag,
    .port_out, .port_oe);
  // -------------------------------------------------------------
  // Clock, vector monitor, bus tasks
  // -------------------------------------------------------------
  always #10 clk = ~clk;
  // Count vector pulses so their exact cycle need not be guessed
  always @(posedge clk) if (take_vector === 1'b1) nvec++;
  task automatic wr(input logic [15:0] a, input logic [13:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Bounded wait for resume; a hang shows as a mismatch
  task automatic wake_wait;
    int k;
    k = 0;
    while (core_hold === 1'b1 && k < 30) begin
      cyc(1);
      k++;
    end
    `CHK("resume", 1'b0, core_hold)
    `CHK("osc_on", 1'b1, osc_drive_on)
  endtask : wake_wait
  task automatic flags(input string s);
    `CHK("pd", pd_m[0], powerdown_flag)
    `CHK("to", to_m[0], timeout_flag)
    $display("test %s done", s);
  endtask : flags
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial begin
    #400000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    pc_now <= $random(seed);
    cyc(2);
    rd(cfg_sleep_pkg::CFG_WORD_OFFSET);
    `CHK("erased", 14'h3fff, d)
    `CHK("vector", 13'h0004, vector_addr)
    pd_m = 1;
    to_m = 1;
    flags("reset");
    // Random words, every oscillator code, both protect patterns
    for (int i = 0; i < 8; i++) begin
      w = $random(seed);
      r = $random(seed);
      w[1:0] = i[1:0];
      {w[13:12], w[5:4]} = i[2] ? 4'hf : 4'h0;
      eeprom_write_req <= r[0];
      wr(cfg_sleep_pkg::CFG_WORD_OFFSET, w);
      rd(cfg_sleep_pkg::CFG_WORD_OFFSET);
      w[10] = 1'b1;
      `CHK("cfg", w, d)
      `CHK("protect", !i[2], prog_mem_protect)
      `CHK("debug", !w[11], debugger_pins)
      `CHK("self_write", r[0] & w[9] & i[2], prog_write_ok)
      `CHK("ee_lock", !w[8], data_eeprom_locked)
      `CHK("lvp", w[7], prog_mode_pin_func)
      `CHK("bor", w[6], brown_out_reset)
      `CHK("powerup_timer", w[6] | !w[3], powerup_timer)
      `CHK("wdt", w[2], watchdog_run)
      `CHK("osc", w[1:0], osc_mode)
    end
    wr(16'h1234, 14'h1555);
    rd(16'h1234);
    `CHK("unmapped", 14'h0000, d)
    $display("test config done");
    // Sleep with gie clear; a disabled flag must not wake
    wr(cfg_sleep_pkg::IRQ_EN_OFFSET, 14'h0001);
    p = $random(seed);
    port_out_in <= p;
    port_oe_in <= ~p;
    wr(cfg_sleep_pkg::SLEEP_CTRL_OFFSET, 14'h0001);
    `CHK("wdt_clear", 1'b1, wdt_clear)
    `CHK("osc_off", 1'b0, osc_drive_on)
    `CHK("prefetch", pc_now + 13'h0001, prefetch_addr)
    @(posedge clk) port_out_in <= ~p;
    irq_flags <= 4'h4;
    cyc(12);
    `CHK("asleep", 1'b1, core_hold)
    `CHK("port_hold", p, port_out)
    `CHK("oe_hold", ~p, port_oe)
    rd(cfg_sleep_pkg::SLEEP_STAT_OFFSET);
    `CHK("status", 14'h0006, d)
    irq_flags <= 4'h5;
    wake_wait();
    cyc(3);
    `CHK("no_vector", 0, nvec)
    `CHK("port_free", ~p, port_out)
    pd_m = 0;
    flags("irq wake");
    // Gie set, flag arrives after the sleep write
    irq_flags <= 4'h0;
    wr(cfg_sleep_pkg::SLEEP_CTRL_OFFSET, 14'h0005);
    irq_flags <= 4'h1;
    wake_wait();
    cyc(3);
    `CHK("vector_once", 1, nvec)
    flags("late irq");
    // Watchdog wake clears the timeout flag, power-up sets both again
    irq_flags <= 4'h0;
    wr(cfg_sleep_pkg::SLEEP_CTRL_OFFSET, 14'h0001);
    @(posedge clk) wdt_timeout <= 1'b1;
    @(posedge clk) wdt_timeout <= 1'b0;
    wake_wait();
    to_m = 0;
    flags("watchdog wake");
    @(posedge clk) por_event <= 1'b1;
    @(posedge clk) por_event <= 1'b0;
    cyc(1);
    pd_m = 1;
    to_m = 1;
    flags("power-up");
    // Pending enabled flag turns sleep into a no-op
    irq_flags <= 4'h1;
    wr(cfg_sleep_pkg::SLEEP_CTRL_OFFSET, 14'h0001);
    `CHK("noop_wdt", 1'b0, wdt_clear)
    cyc(2);
    `CHK("noop_hold", 1'b0, core_hold)
    `CHK("noop_osc", 1'b1, osc_drive_on)
    flags("no-op sleep");
    // Master clear ends sleep with a reset
    irq_flags <= 4'h0;
    wr(cfg_sleep_pkg::SLEEP_CTRL_OFFSET, 14'h0001);
    @(posedge clk) master_clear_n <= 1'b0;
    cyc(6);
    `CHK("master_clear_n_reset", 1'b1, core_reset)
    `CHK("master_clear_n_hold", 1'b0, core_hold)
    master_clear_n <= 1'b1;
    cyc(6);
    `CHK("master_clear_n_done", 1'b0, core_reset)
    $display("test master clear done");
    wr(cfg_sleep_pkg::SLEEP_CTRL_OFFSET, 14'h0002);
    `CHK("watchdog_clear_instr", 1'b1, wdt_clear)
    pd_m = 1;
    flags("watchdog clear");
    finish_test();
  end
endmodule : config_word_sleep_wakeup_test

bind cfg_sleep_ctrl cfg_sleep_ctrl_asserts cfg_sleep_ctrl_asserts_inst (.clk, .rst_b, .addr,
  .wdata, .wr_stb, .rd_stb, .rdata, .por_event, .wdt_timeout, .pc_now, .irq_flags,
  .prog_mem_protect, .debugger_pins, .data_eeprom_locked, .brown_out_reset, .powerup_timer,
  .watchdog_run, .osc_mode, .osc_drive_on, .wdt_clear, .core_hold, .take_vector,
  .prefetch_addr, .vector_addr, .powerdown_flag, .timeout_flag, .port_out, .port_oe);

// ### verilog/cfg_sleep_ctrl.sv
// Configuration word decoder with sleep entry and wake-up control
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

// Overview of operation
// - Code protect field 11 off, 00 all
// - Debug bit low dedicates pins six, seven
// - Program self-write allowed only when bit set
// - Data EEPROM protected while bit is zero
// - Low-voltage bit gives programming pin function
// - Brown-out enable forces power-up timer on
// - Power-up timer enable is active low
// - Watchdog runs when its enable bit set
// - Oscillator field selects one of four modes
// - Unimplemented bit ten always reads one
// - Erased configuration word reads all ones
// - Sleep clears watchdog, sets timeout, clears powerdown
// - Ports hold their drive state during sleep
// - Wake by master clear, watchdog, interrupts
// - Powerdown set at power-up; watchdog wake from sleep clears timeout
// - Only clockless peripherals wake the device
// - Sleep prefetches the following instruction
// - Enabled interrupt wakes; global enable picks vector
// - Pending enabled interrupt turns sleep into no-op
// - Late interrupt still completes sleep, then wakes
module cfg_sleep_ctrl (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Register port
  input  wire logic [15:0]          addr,
  input  wire logic [13:0]          wdata,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  output logic      [13:0]          rdata,
  // Core events
  input  wire logic                 por_event,
  input  wire logic                 master_clear_n,
  input  wire logic                 wdt_timeout,
  input  wire logic                 eeprom_write_req,
  input  wire logic [12:0]          pc_now,
  // Interrupt flags from clockless sources: ext pin, port-B change, async
  // peripheral, eeprom done; clocked peripherals are not wired here
  input  wire logic [3:0]           irq_flags,
  // Port drive state from the core
  input  wire logic [7:0]           port_out_in,
  input  wire logic [7:0]           port_oe_in,
  // Decoded configuration
  output logic                      prog_mem_protect,
  output logic                      debugger_pins,
  output logic                      prog_write_ok,
  output logic                      data_eeprom_locked,
  output logic                      prog_mode_pin_func,
  output logic                      brown_out_reset,
  output logic                      powerup_timer,
  output logic                      watchdog_run,
  output logic      [1:0]           osc_mode,
  // Sleep outputs
  output logic                      osc_drive_on,
  output logic                      wdt_clear,
  output logic                      core_reset,
  output logic                      core_hold,
  output logic                      take_vector,
  output logic      [12:0]          prefetch_addr,
  output logic      [12:0]          vector_addr,
  output logic                      powerdown_flag,
  output logic                      timeout_flag,
  output logic      [7:0]           port_out,
  output logic      [7:0]           port_oe
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  // Stored configuration word
  logic [13:0]               cfg_r;

  // Interrupt enables
  logic [3:0]                irq_en_r;
  logic                      gie_r;

  // Requests decoded from bus writes
  logic                      sleep_req;
  logic                      watchdog_clear_instr_req;

  // Master clear pin, synchronised
  logic [2:0]                master_clear_n_sync_r;
  logic                      master_clear_n_low;

  // Any enabled wake source
  logic                      irq_wake;

  // Sleep sequencer
  cfg_sleep_pkg::sleep_state_t state_r;
  cfg_sleep_pkg::sleep_state_t state_nxt;

  // Oscillator restart delay
  logic [7:0]                osc_cnt_r;

  // Wake cause
  logic                      wake_wdt_r;
  logic                      gie_at_wake_r;

  // Protection field read as a pair; equal pairs are the programmer's duty
  // Unequal pairs read as open, the safe side
  function automatic logic cp_locked(input logic [13:0] w);
    cp_locked = (w[cfg_sleep_pkg::CP_HI_POS +: 2] == cfg_sleep_pkg::CP_ALL) &&
                (w[cfg_sleep_pkg::CP_LO_POS +: 2] == cfg_sleep_pkg::CP_ALL);
  endfunction : cp_locked

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  assign sleep_req  = wr_stb && (addr == cfg_sleep_pkg::SLEEP_CTRL_OFFSET)
                      && wdata[cfg_sleep_pkg::CTRL_SLEEP_POS];
  assign watchdog_clear_instr_req = wr_stb && (addr == cfg_sleep_pkg::SLEEP_CTRL_OFFSET)
                      && wdata[cfg_sleep_pkg::CTRL_WATCHDOG_CLEAR_INSTR_POS];

  // Configuration word, erased state on reset; bit ten cannot be programmed
  // Fields act one cycle later via decode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_r <= cfg_sleep_pkg::CFG_WORD_RESET;
    end else if (wr_stb && addr == cfg_sleep_pkg::CFG_WORD_OFFSET) begin
      cfg_r <= wdata | (14'h0001 << cfg_sleep_pkg::UNIMPL_POS);
    end
  end

  // Interrupt enables and the global enable
  // Reset clears both, so nothing wakes early
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_en_r <= 4'h0;
      gie_r    <= 1'b0;
    end else if (wr_stb && addr == cfg_sleep_pkg::IRQ_EN_OFFSET) begin
      irq_en_r <= wdata[3:0];
    end else if (wr_stb && addr == cfg_sleep_pkg::SLEEP_CTRL_OFFSET) begin
      gie_r <= wdata[cfg_sleep_pkg::CTRL_GIE_POS];
    end
  end

  // Read data, valid in the cycle after the strobe only
  // Zero otherwise, so nothing stale is seen
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 14'h0000;
    end else if (rd_stb) begin
      // Unmapped addresses read zero
      unique case (addr)
        cfg_sleep_pkg::CFG_WORD_OFFSET:   rdata <= cfg_r;
        cfg_sleep_pkg::SLEEP_CTRL_OFFSET: rdata <= {11'h000, gie_r, 2'h0};
        cfg_sleep_pkg::SLEEP_STAT_OFFSET: rdata <= {9'h000, take_vector, osc_drive_on,
                                                    core_hold, timeout_flag, powerdown_flag};
        cfg_sleep_pkg::IRQ_EN_OFFSET:     rdata <= {10'h000, irq_en_r};
        default:                          rdata <= 14'h0000;
      endcase
    end else begin
      rdata <= 14'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prog_mem_protect   <= 1'b0;
      debugger_pins      <= 1'b0;
      prog_write_ok      <= 1'b0;
      data_eeprom_locked <= 1'b0;
      prog_mode_pin_func <= 1'b1;
      brown_out_reset    <= 1'b1;
      powerup_timer      <= 1'b1;
      watchdog_run       <= 1'b0;
      osc_mode           <= cfg_sleep_pkg::OSC_RC;
    end else begin
      // Protection and debugger pins
      prog_mem_protect   <= cp_locked(cfg_r);
      debugger_pins      <= !cfg_r[cfg_sleep_pkg::DEBUG_POS];

      // Self-write needs permit, request and open memory
      prog_write_ok      <= cfg_r[cfg_sleep_pkg::WRT_POS] && eeprom_write_req
                            && !cp_locked(cfg_r);

      // Data lock is active low in the word
      data_eeprom_locked <= !cfg_r[cfg_sleep_pkg::CPD_POS];

      // Programming pin function
      prog_mode_pin_func <= cfg_r[cfg_sleep_pkg::LVP_POS];

      // Brown-out overrides the timer enable
      brown_out_reset    <= cfg_r[cfg_sleep_pkg::BOR_EN_POS];
      powerup_timer      <= cfg_r[cfg_sleep_pkg::BOR_EN_POS]
                            || !cfg_r[cfg_sleep_pkg::POWERUP_TIMER_N_POS];

      // Watchdog keeps running through sleep when enabled
      watchdog_run       <= cfg_r[cfg_sleep_pkg::WDT_EN_POS];

      // Oscillator mode passes straight through
      osc_mode           <= cfg_r[cfg_sleep_pkg::OSC_POS +: 2];
    end
  end

  // ---------------------------------------------------------------
  // Master clear pin synchroniser
  // ---------------------------------------------------------------
  // Pin is asynchronous; a low level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      master_clear_n_sync_r <= 3'h7;
    end else begin
      master_clear_n_sync_r <= {master_clear_n_sync_r[1:0], master_clear_n};
    end
  end
  // Stage one is never read: it may be metastable
  assign master_clear_n_low = (master_clear_n_sync_r[2:1] == 2'b00);

  // Only sources with their own enable may wake, whatever the global enable
  // Clocked peripherals are not wired in
  assign irq_wake = |(irq_flags & irq_en_r);

  // ---------------------------------------------------------------
  // Sleep state machine
  // ---------------------------------------------------------------
  // Master clear overrides every other decision
  // An enabled interrupt flag in the sleep write cycle makes it a no-op; a watchdog timeout does not
  always_comb begin
    // Hold by default
    state_nxt = state_r;
    unique case (state_r)
      cfg_sleep_pkg::ST_RUN: begin
        // Pending enabled flag before sleep: the instruction is a no-op
        if (sleep_req && !irq_wake) begin
          state_nxt = cfg_sleep_pkg::ST_SLEEP;
        end
      end
      // Oscillator off until a wake source
      cfg_sleep_pkg::ST_SLEEP: begin
        if (irq_wake || wdt_timeout) begin
          state_nxt = cfg_sleep_pkg::ST_WAKE;
        end
      end
      // Oscillator back on; let it settle
      cfg_sleep_pkg::ST_WAKE: begin
        if (osc_cnt_r == cfg_sleep_pkg::OSC_RESTART_CYC) begin
          state_nxt = cfg_sleep_pkg::ST_RESUME;
        end
      end
      // One cycle to launch the prefetch
      cfg_sleep_pkg::ST_RESUME: begin
        state_nxt = cfg_sleep_pkg::ST_RUN;
      end
      default: state_nxt = cfg_sleep_pkg::ST_RUN;
    endcase
    if (master_clear_n_low) begin
      state_nxt = cfg_sleep_pkg::ST_RUN;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= cfg_sleep_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Oscillator restart count while waking
  // Cleared elsewhere so each wake waits in full
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_cnt_r <= 8'h00;
    end else if (state_r == cfg_sleep_pkg::ST_WAKE) begin
      osc_cnt_r <= osc_cnt_r + 8'h01;
    end else begin
      osc_cnt_r <= 8'h00;
    end
  end

  // Wake cause and global enable captured at wake
  // A watchdog wake never vectors
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_wdt_r    <= 1'b0;
      gie_at_wake_r <= 1'b0;
    end else if (state_r == cfg_sleep_pkg::ST_SLEEP && state_nxt == cfg_sleep_pkg::ST_WAKE) begin
      wake_wdt_r    <= wdt_timeout && !irq_wake;
      gie_at_wake_r <= gie_r && irq_wake;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Power-on wins; sleep entry and watchdog wake follow in that order
  // Events beat a software clear in one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      powerdown_flag <= 1'b1;
      timeout_flag   <= 1'b1;
    end else if (por_event) begin
      powerdown_flag <= 1'b1;
      timeout_flag   <= 1'b1;
    end else if (state_r == cfg_sleep_pkg::ST_RUN && state_nxt == cfg_sleep_pkg::ST_SLEEP) begin
      powerdown_flag <= 1'b0;
      timeout_flag   <= 1'b1;
    end else if (state_r == cfg_sleep_pkg::ST_SLEEP && wdt_timeout && !irq_wake) begin
      timeout_flag   <= 1'b0;
    // Software clear marks a normal run
    end else if (watchdog_clear_instr_req) begin
      powerdown_flag <= 1'b1;
      timeout_flag   <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Core-facing controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_drive_on  <= 1'b1;
      wdt_clear     <= 1'b0;
      core_reset    <= 1'b0;
      core_hold     <= 1'b0;
      take_vector   <= 1'b0;
      prefetch_addr <= 13'h0000;
      vector_addr   <= cfg_sleep_pkg::IRQ_VECTOR;
    end else begin
      // Watchdog and postscaler clear on a completed sleep or software clear
      wdt_clear     <= watchdog_clear_instr_req || (state_r == cfg_sleep_pkg::ST_RUN
                       && state_nxt == cfg_sleep_pkg::ST_SLEEP);

      // Driver off only while sleeping
      osc_drive_on  <= (state_nxt != cfg_sleep_pkg::ST_SLEEP);

      // Master clear resets; it is no wake-up
      core_reset    <= master_clear_n_low;

      // Core stalls through sleep and restart
      core_hold     <= (state_nxt == cfg_sleep_pkg::ST_SLEEP)
                       || (state_nxt == cfg_sleep_pkg::ST_WAKE);
      // Vector follows one instruction after resume if global enable was set
      take_vector   <= (state_r == cfg_sleep_pkg::ST_RESUME) && gie_at_wake_r;
      vector_addr   <= cfg_sleep_pkg::IRQ_VECTOR;
      // Captured even for a no-op sleep
      if (sleep_req && state_r == cfg_sleep_pkg::ST_RUN) begin
        prefetch_addr <= pc_now + 13'h0001;
      end
    end
  end

  // Port drive frozen while asleep; captured from the core otherwise
  // Resume cycle skipped so no stale value leaks
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port_out <= 8'h00;
      port_oe  <= 8'h00;
    end else if (state_nxt == cfg_sleep_pkg::ST_RUN || state_nxt == cfg_sleep_pkg::ST_RESUME) begin
      if (state_r == cfg_sleep_pkg::ST_RUN) begin
        port_out <= port_out_in;
        port_oe  <= port_oe_in;
      end
    end else begin
      // Keep drive: high, low or released
      port_out <= port_out;
      port_oe  <= port_oe;
    end
  end

endmodule : cfg_sleep_ctrl

// ### verilog/cfg_sleep_pkg.sv
// Package: configuration word layout, register offsets and sleep constants
package cfg_sleep_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_WORD_OFFSET   = 16'h2007;
  localparam logic [15:0] SLEEP_CTRL_OFFSET = 16'h2008;
  localparam logic [15:0] SLEEP_STAT_OFFSET = 16'h2009;
  localparam logic [15:0] IRQ_EN_OFFSET     = 16'h200a;

  // ---------------------------------------------------------------
  // Configuration word fields
  // ---------------------------------------------------------------
  localparam logic [13:0] CFG_WORD_RESET    = 14'h3fff;
  localparam int          CP_HI_POS         = 12;
  localparam int          DEBUG_POS         = 11;
  localparam int          UNIMPL_POS        = 10;
  localparam int          WRT_POS           = 9;
  localparam int          CPD_POS           = 8;
  localparam int          LVP_POS           = 7;
  localparam int          BOR_EN_POS        = 6;
  localparam int          CP_LO_POS         = 4;
  localparam int          POWERUP_TIMER_N_POS        = 3;
  localparam int          WDT_EN_POS        = 2;
  localparam int          OSC_POS           = 0;

  // Code protect and oscillator encodings
  localparam logic [1:0]  CP_OFF            = 2'h3;
  localparam logic [1:0]  CP_ALL            = 2'h0;
  localparam logic [1:0]  OSC_RC            = 2'h3;
  localparam logic [1:0]  OSC_HS            = 2'h2;
  localparam logic [1:0]  OSC_XT            = 2'h1;
  localparam logic [1:0]  OSC_LP            = 2'h0;

  // ---------------------------------------------------------------
  // Sleep control/status fields
  // ---------------------------------------------------------------
  localparam int          CTRL_SLEEP_POS    = 0;
  localparam int          CTRL_WATCHDOG_CLEAR_INSTR_POS   = 1;
  localparam int          CTRL_GIE_POS      = 2;
  localparam int          STAT_PD_POS       = 0;
  localparam int          STAT_TO_POS       = 1;
  localparam int          STAT_ASLEEP_POS   = 2;
  localparam int          STAT_OSC_ON_POS   = 3;
  localparam int          STAT_VECTOR_POS   = 4;
  localparam int          IRQ_SRC_W         = 4;
  localparam logic [12:0] IRQ_VECTOR        = 13'h0004;
  localparam logic [7:0]  OSC_RESTART_CYC   = 8'h04;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_WAKE  = 4'b0100,
    ST_RESUME= 4'b1000
  } sleep_state_t;

endpackage : cfg_sleep_pkg
